// ==== dv/ser_28to4_tx_tb.sv ====
// self-checking bench for the 28-to-4 lane serializer
// assumes ser_link_partner as source and receiver, clk 125 MHz
`timescale 1ns/1ns
`default_nettype none
module ser_28to4_tx_tb
    import ser_pkg::*;
;
    logic        clk, rst_n, sel, shut_n, run, pclk, fp, fn, den;
    logic [3:0]  lp, ln;
    ser_word_t   word, data, rx_word;
    logic [15:0] rx_cnt, c0;
    logic [4:0]  hi_cnt;
    int          err_total, checked;

    // clock at 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ser_28to4_tx dut (.clk(clk), .rst_n(rst_n), .parallel_input_clock(pclk),
        .capture_edge_select(sel), .shutdown_clear_n(shut_n), .parallel_data_bit(data),
        .serial_lane1_pos(lp[0]), .serial_lane1_neg(ln[0]), .serial_lane2_pos(lp[1]),
        .serial_lane2_neg(ln[1]), .serial_lane3_pos(lp[2]), .serial_lane3_neg(ln[2]),
        .serial_lane4_pos(lp[3]), .serial_lane4_neg(ln[3]), .forwarded_clock_pos(fp),
        .forwarded_clock_neg(fn), .serial_drive_en(den));

    ser_link_partner peer (.clk(clk), .run(run), .word(word), .pclk(pclk), .data(data),
        .fwd_pos(fp), .lane_pos(lp), .rx_word(rx_word), .rx_cnt(rx_cnt), .hi_cnt(hi_cnt));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one word across the link on the chosen capture edge
    task automatic t_xfer(input logic s, input ser_word_t w);
        word = w;
        sel  = s;
        cyc(140);
        check("rx_word", w, rx_word);
        check("fwd_high", 5'h0C, hi_cnt);
        check("drive_en", 1'b1, den);
        check("pairs", {~lp, ~fp}, {ln, fn});
        c0 = rx_cnt;
        cyc(200);
        check("frames", 16'h000A, rx_cnt - c0);
        $display("test xfer sel=%0d done", s);
    endtask

    // shutdown clears and silences, then the link recovers
    task automatic t_shut();
        shut_n = 1'b0;
        cyc(3);
        check("shut_out", 11'h000, {lp, ln, fp, fn, den});
        shut_n = 1'b1;
        cyc(4);
        check("after_clr", 11'h000, {lp, ln, fp, fn, den});
        word = 28'h0F0F0F1;
        cyc(140);
        check("rx_again", 28'h0F0F0F1, rx_word);
        $display("test shut done");
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // main sequence: reset two cycles, then scenarios
    initial begin
        err_total = 0;
        checked   = 0;
        rst_n     = 1'b0;
        sel       = 1'b1;
        shut_n    = 1'b1;
        run       = 1'b1;
        word      = 28'h0000000;
        cyc(2);
        rst_n = 1'b1;
        cyc(2);
        check("reset_out", 11'h000, {lp, ln, fp, fn, den});
        t_xfer(1'b1, 28'hA5C396E);
        t_xfer(1'b0, 28'h35AC691);
        t_shut();
        t_xfer(1'b1, 28'hFFFFFFE);
        close_out();
    end

    // watchdog well past the expected run length
    initial begin
        #40000;
        err_total++;
        close_out();
    end
endmodule
`default_nettype wire

// ==== dv/ser_link_partner.sv ====
// parallel source and matching receiver model around the serializer
// assumes clk at 125 MHz and a 20-clk (160 ns) input clock period
`timescale 1ns/1ns
`default_nettype none
module ser_link_partner
    import ser_pkg::*;
(
    // system
    input  wire logic       clk,
    input  wire logic       run,
    input  wire ser_word_t  word,
    // source side
    output logic            pclk,
    output var ser_word_t  data,
    // receive side
    input  wire logic       fwd_pos,
    input  wire logic [3:0] lane_pos,
    output var ser_word_t  rx_word,
    output logic [15:0]     rx_cnt,
    output logic [4:0]      hi_cnt
);
    logic       fp_d = 1'b0;
    logic [4:0] ph   = 5'h00;
    logic [4:0] hc   = 5'h00;
    ser_word_t  acc;
    logic [15:0] rc = 16'h0000;
    // steady input clock
    // period scaled to the bench; held low while stopped, free running while run is high
    initial begin
        pclk = 1'b0;
        #5;
        forever begin
            #80;
            pclk = run ? ~pclk : 1'b0;
        end
    end
    assign data = word;
    // rebuild parallel word
    // mid-cell sampling, lane n bit k lands at 7n+k; also times the high phase
    assign rx_cnt = rc;
    always @(posedge clk) begin
        fp_d <= fwd_pos;
        if (fwd_pos && !fp_d) begin
            ph <= 5'h01;
            hc <= 5'h01;
        end else begin
            if (ph != 5'h00 && ph < 5'h14) ph <= ph + 5'h01;
            if (fwd_pos) hc <= hc + 5'h01;
            if (!fwd_pos && fp_d) hi_cnt <= hc;
        end
        if (ph != 5'h00 && ph % 3 == 1) begin
            for (int n = 0; n < 4; n++) acc[7*n + (ph-1)/3] = lane_pos[n];
            if (ph == 5'h13) begin
                rx_word <= acc;
                rc      <= rc + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verilog/ser_28to4_tx.sv ====
// 28-bit parallel to four serial lanes plus forwarded clock transmitter
// assumes clk far faster than the input clock; all pins are asynchronous to clk
`timescale 1ns/1ns
`default_nettype none
`include "ser_consts.svh"

module ser_28to4_tx
    import ser_pkg::*;
(
    // system
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // parallel side pins
    input  wire logic                       parallel_input_clock,
    input  wire logic                       capture_edge_select,
    input  wire logic                       shutdown_clear_n,
    input  wire logic [`SER_WORD_BITS-1:0]  parallel_data_bit,
    // serial side pins
    output logic                            serial_lane1_pos,
    output logic                            serial_lane1_neg,
    output logic                            serial_lane2_pos,
    output logic                            serial_lane2_neg,
    output logic                            serial_lane3_pos,
    output logic                            serial_lane3_neg,
    output logic                            serial_lane4_pos,
    output logic                            serial_lane4_neg,
    output logic                            forwarded_clock_pos,
    output logic                            forwarded_clock_neg,
    output logic                            serial_drive_en
);

    // shutdown acts as an asynchronous clear beside the system reset
    logic        clear_n;
    assign clear_n = rst_n & shutdown_clear_n;

    logic        pclk_s1;
    logic        pclk_s2;
    logic        pclk_s3;
    logic        sel_s1;
    logic        sel_s2;
    ser_word_t   data_s1;
    ser_word_t   data_s2;
    logic        rise;
    logic        fall;
    logic        capture;
    ser_word_t   hold_reg;
    ser_count_t  cnt_reg;
    ser_count_t  period_reg;
    logic        seen_reg;
    logic        valid_reg;
    ser_count_t  acc_reg;
    ser_count_t  acc_sum;
    ser_count_t  acc_next;
    ser_bitpos_t bit_reg;
    ser_bitpos_t bit_next;
    ser_word_t   word_reg;
    ser_word_t   word_next;
    logic [`SER_LANES-1:0] lane_pos_reg;
    logic [`SER_LANES-1:0] lane_neg_reg;
    logic        fwd_pos_reg;
    logic        fwd_neg_reg;
    logic        drv_en_reg;
    logic        lock_now;
    logic [1:0]  warm_reg;

    // two-flop synchronisers for the clock, select and data pins; s3 only feeds edge detection
    always_ff @(posedge clk or negedge clear_n) begin
        if (!clear_n) begin
            pclk_s1 <= 1'b0;
            pclk_s2 <= 1'b0;
            pclk_s3 <= 1'b0;
            sel_s1  <= 1'b0;
            sel_s2  <= 1'b0;
            data_s1 <= '0;
            data_s2 <= '0;
            warm_reg <= 2'h0;
        end else begin
            pclk_s1 <= parallel_input_clock;
            pclk_s2 <= pclk_s1;
            pclk_s3 <= pclk_s2;
            sel_s1  <= capture_edge_select;
            sel_s2  <= sel_s1;
            data_s1 <= parallel_data_bit;
            data_s2 <= data_s1;
            if (warm_reg != `SER_SYNC_WARM) begin
                warm_reg <= warm_reg + 2'h1;
            end
        end
    end

    // edges count once s3 holds a real pin sample; a high pin at release fakes none
    assign rise = (warm_reg == `SER_SYNC_WARM) & pclk_s2 & ~pclk_s3;
    assign fall = (warm_reg == `SER_SYNC_WARM) & ~pclk_s2 & pclk_s3;
    assign capture = sel_s2 ? rise : fall;

    always_ff @(posedge clk or negedge clear_n) begin
        if (!clear_n) begin
            hold_reg <= '0;
        end else if (capture) begin
            hold_reg <= data_s2;
        end
    end

    // period measurement; timing runs only after one full period is known
    always_ff @(posedge clk or negedge clear_n) begin
        if (!clear_n) begin
            cnt_reg    <= '0;
            period_reg <= '0;
            seen_reg   <= 1'b0;
            valid_reg  <= 1'b0;
        end else if (rise) begin
            period_reg <= cnt_reg + ser_count_t'(1);
            cnt_reg    <= '0;
            seen_reg   <= 1'b1;
            valid_reg  <= seen_reg;
        end else if (&cnt_reg) begin
            seen_reg   <= 1'b0; // input clock stopped: lose lock
            valid_reg  <= 1'b0;
        end else begin
            cnt_reg    <= cnt_reg + ser_count_t'(1);
        end
    end

    // fractional divider, seven steps per measured period
    always_comb begin
        acc_sum  = acc_reg + ser_count_t'(`SER_SLICE_BITS);
        acc_next = acc_sum;
        bit_next = bit_reg;
        if (rise) begin
            acc_next = '0;
            bit_next = '0;
        end else if (valid_reg && acc_sum >= period_reg && bit_reg != `SER_LAST_POS) begin
            acc_next = acc_sum - period_reg;
            bit_next = bit_reg + 3'h1;
        end
    end

    // divider state; cleared by shutdown, which stops the bit timing
    always_ff @(posedge clk or negedge clear_n) begin
        if (!clear_n) begin
            acc_reg <= '0;
            bit_reg <= '0;
        end else begin
            acc_reg <= acc_next;
            bit_reg <= bit_next;
        end
    end

    // word in flight reloads at each input rise; latency one period with rising capture, half a period with falling capture
    // word passes unchanged
    assign word_next = rise ? hold_reg : word_reg;

    // lock seen one cycle early so the first frame starts with its own rise
    assign lock_now = valid_reg | (rise & seen_reg);

    always_ff @(posedge clk or negedge clear_n) begin
        if (!clear_n) begin
            word_reg <= '0;
        end else begin
            word_reg <= word_next;
        end
    end

    // lane n bit k is input 7n+k
    genvar g;
    generate
        for (g = 0; g < `SER_LANES; g = g + 1) begin : g_lane
            always_ff @(posedge clk or negedge clear_n) begin
                if (!clear_n) begin
                    lane_pos_reg[g] <= 1'b0;
                    lane_neg_reg[g] <= 1'b0;
                end else begin
                    lane_pos_reg[g] <= lock_now & word_next[g*`SER_SLICE_BITS + bit_next];
                    lane_neg_reg[g] <= lock_now & ~word_next[g*`SER_SLICE_BITS + bit_next];
                end
            end
        end
    endgenerate

    // forwarded clock high for bits 0 to 3
    always_ff @(posedge clk or negedge clear_n) begin
        if (!clear_n) begin
            fwd_pos_reg <= 1'b0;
            fwd_neg_reg <= 1'b0;
        end else begin
            fwd_pos_reg <= lock_now & (bit_next < `SER_FWD_HIGH);
            fwd_neg_reg <= lock_now & ~(bit_next < `SER_FWD_HIGH);
        end
    end

    // drivers off while shut down or unlocked
    always_ff @(posedge clk or negedge clear_n) begin
        if (!clear_n) begin
            drv_en_reg <= 1'b0;
        end else begin
            drv_en_reg <= lock_now;
        end
    end

    assign serial_lane1_pos    = lane_pos_reg[0];
    assign serial_lane1_neg    = lane_neg_reg[0];
    assign serial_lane2_pos    = lane_pos_reg[1];
    assign serial_lane2_neg    = lane_neg_reg[1];
    assign serial_lane3_pos    = lane_pos_reg[2];
    assign serial_lane3_neg    = lane_neg_reg[2];
    assign serial_lane4_pos    = lane_pos_reg[3];
    assign serial_lane4_neg    = lane_neg_reg[3];
    assign forwarded_clock_pos = fwd_pos_reg;
    assign forwarded_clock_neg = fwd_neg_reg;
    assign serial_drive_en     = drv_en_reg;

    // checks
    sequence s_locked_rise;
        rise && valid_reg;
    endsequence

    sequence s_bit0_high;
        fwd_pos_reg && bit_reg == 3'h0;
    endsequence

    property p_capture;
        @(posedge clk) disable iff (!clear_n) capture |=> hold_reg == $past(data_s2);
    endproperty
    a_capture: assert property (p_capture) else $error("word not captured");

    property p_no_wrong_edge;
        @(posedge clk) disable iff (!clear_n)
            ((fall && sel_s2) || (rise && !sel_s2)) |=> hold_reg == $past(hold_reg);
    endproperty
    a_no_wrong_edge: assert property (p_no_wrong_edge) else $error("captured on wrong edge");

    property p_step_one;
        @(posedge clk) disable iff (!clear_n)
            !rise && bit_next != bit_reg |-> bit_next == bit_reg + 3'h1;
    endproperty
    a_step_one: assert property (p_step_one) else $error("bit position skipped");

    property p_seven_steps;
        @(posedge clk) disable iff (!clear_n) s_locked_rise |-> bit_reg == `SER_LAST_POS;
    endproperty
    a_seven_steps: assert property (p_seven_steps) else $error("period ended before bit 6");

    property p_pair;
        @(posedge clk) disable iff (!clear_n)
            drv_en_reg |-> (lane_pos_reg ^ lane_neg_reg) == 4'hF && fwd_pos_reg != fwd_neg_reg;
    endproperty
    a_pair: assert property (p_pair) else $error("pair not complementary");

    property p_fwd_rise;
        @(posedge clk) disable iff (!clear_n) $rose(fwd_pos_reg) |-> $past(rise);
    endproperty
    a_fwd_rise: assert property (p_fwd_rise) else $error("forwarded clock rose off input edge");

    property p_shutdown;
        @(posedge clk) disable iff (!rst_n)
            !shutdown_clear_n |-> !serial_drive_en && !forwarded_clock_pos;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("drivers on in shutdown");

    property p_clear;
        @(posedge clk) disable iff (!rst_n)
            !shutdown_clear_n |-> hold_reg == '0 && word_reg == '0 && bit_reg == 3'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("registers not cleared");

    property p_align;
        @(posedge clk) disable iff (!clear_n)
            s_locked_rise |=> s_bit0_high ##0 serial_lane1_pos == $past(hold_reg[0]);
    endproperty
    a_align: assert property (p_align) else $error("bit 0 not aligned to clock rise");

    property p_lane4_map;
        @(posedge clk) disable iff (!clear_n)
            s_locked_rise |=> serial_lane4_pos == $past(hold_reg[21]);
    endproperty
    a_lane4_map: assert property (p_lane4_map) else $error("lane 4 mapping wrong");

    property p_fwd_fall;
        @(posedge clk) disable iff (!clear_n)
            $fell(fwd_pos_reg) && $past(valid_reg) |-> bit_reg == `SER_FWD_HIGH;
    endproperty
    a_fwd_fall: assert property (p_fwd_fall) else $error("forwarded clock fell off bit 4");

endmodule

`default_nettype wire

// ==== verilog/ser_consts.svh ====
// constants for the 28-to-4 lane serializer: lane shape, timing, sizes
// assumes inclusion by bare name from the package and the top module
// What this block does
// - all 28 parallel inputs are captured together once per input clock period on one edge.
// - edge select high captures on the rising input clock edge, low on the falling edge.
// - a bit timing seven times the input clock rate shifts each word out as 7-bit slices.
// - four serial lanes plus a forwarded clock leave as complementary output pairs.
// - the forwarded clock follows the input clock at the input clock frequency.
// - while shutdown is low the timing stops and all output drivers are disabled.
// - a low shutdown asynchronously clears every internal register while it stays low.
// - the word appears unchanged at a matching receiver with no framing added.
// - bit k of each lane starts k sevenths of a period after the forwarded clock rises.
`ifndef SER_CONSTS_SVH
`define SER_CONSTS_SVH

`define SER_LANES        4
`define SER_SLICE_BITS   7
`define SER_WORD_BITS    28
`define SER_LAST_POS     3'h6
`define SER_FWD_HIGH     3'h4
`define SER_PERIOD_W     16
`define SER_CLK_MHZ      125
`define SER_LOCK_MIN_MHZ 20
`define SER_LOCK_MAX_MHZ 65
`define SER_SYNC_WARM    2'h3

`endif

// ==== verilog/ser_pkg.sv ====
// types shared by the serializer
// assumes ser_consts.svh is on the include path
`default_nettype none
`include "ser_consts.svh"

package ser_pkg;
    typedef logic [2:0]                  ser_bitpos_t;
    typedef logic [`SER_WORD_BITS-1:0]   ser_word_t;
    typedef logic [`SER_PERIOD_W-1:0]    ser_count_t;
endpackage

`default_nettype wire
